/* File: counter_period_measurement_test.sv */
/* Bench of cpm_counter: bus tasks, window driver and a queue model of the FIFO.
   Assumes cpm_source drives the count pin with an 8-cycle period. */
`timescale 1ns/1ps
`include "cpm_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end
module counter_period_measurement_test;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg window_in = 1'b0;
  reg [3:0] addr_in = 4'h0;
  reg [31:0] wdata_in = 32'h0;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg ovr = 1'b0;
  reg [31:0] v;
  reg [32:0] q [$];
  wire count_in;
  wire [31:0] rdata_out;
  wire done_out;
  wire data_valid_out;
  integer n_errors = 0;
  integer checks_done = 0;
  integer cycles = 0;
  integer seed = 32'h4D27;
  integer i;
  integer acc = 0;
  integer n [0:5];
  always #10 clk_in = ~clk_in;
  cpm_source src (.clk_in(clk_in), .count_out(count_in));
  cpm_counter dut (.clk_in(clk_in), .rst_in(rst_in), .window_in(window_in), .count_in(count_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .done_out(done_out), .data_valid_out(data_valid_out));
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
    end
  endtask
  // Disarm first: of control writes, only a 0 to 1 change of arm clears the count and FIFO
  task arm(input [1:0] m, input wf, input cf);
    begin
      wr(4'h0, 32'h0);
      @(posedge clk_in);
      addr_in <= 4'h0;
      wdata_in <= {27'h0, m, cf, wf, 1'b1};
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
      `CHK(v[4:0], {m, cf, wf, 1'b1})
      `CHK(done_out, 1'b0)
      q.delete();
      ovr = 1'b0;
    end
  endtask
  task seg(input lv, input integer k);
    begin
      window_in <= lv;
      repeat (k * 8) @(posedge clk_in);
    end
  endtask
  // Window edges sit mid-way between count edges, so no count edge is lost
  task align;
    begin
      @(posedge count_in);
      repeat (2) @(posedge clk_in);
    end
  endtask
  task push(input [32:0] x);
    begin
      if (q.size() < `CPM_FIFO_DEPTH) q.push_back(x);
      else ovr = 1'b1;
    end
  endtask
  task drain(input integer k);
    begin
      acc = 0;
      repeat (k) begin
        rd(`CPM_OFF_DATA);
        if (q.size() == 0) `CHK(v, 32'h0)
        else if (!q[0][32]) begin
          `CHK(v, q[0][31:0])
          acc = acc + v;
        end
        if (q.size() != 0) q.delete(0); // Head leaves the model on every read; the partial first value is read but not checked
      end
      rd(`CPM_OFF_CTRL);
      `CHK(data_valid_out, 1'b0)
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`CPM_OFF_CTRL); `CHK(v, `CPM_CTRL_RESET)
    rd(4'hA); `CHK(v, 32'h0)
    for (i = 0; i < 6; i++) n[i] = 2 + $unsigned($random(seed)) % 4;
    seg(1, 1);
    seg(0, 1);
    arm(`CPM_MODE_PERIOD, 1'b0, 1'b0);
    rd(`CPM_OFF_CTRL); `CHK(v[4:0], 5'h01)
    rd(`CPM_OFF_COUNT); `CHK(v, 32'h0)
    align;
    seg(1, 1);
    seg(0, n[0] - 1);
    seg(1, 2);
    rd(`CPM_OFF_SAVE); `CHK(v, n[0])
    seg(0, 3);
    seg(1, 3);
    rd(`CPM_OFF_STATUS); `CHK(v[1], 1'b1)
    `CHK(done_out, 1'b1)
    rd(`CPM_OFF_SAVE); `CHK(v, n[0])
    arm(`CPM_MODE_PERIOD, 1'b1, 1'b1);
    align;
    seg(0, 1);
    seg(1, n[1] - 1);
    seg(0, 2);
    rd(`CPM_OFF_SAVE); `CHK(v, n[1])
    arm(`CPM_MODE_SEMI, 1'b0, 1'b0);
    align;
    seg(1, n[2]);
    seg(0, 2);
    rd(`CPM_OFF_SAVE); `CHK(v, n[2])
    seg(1, 1);
    seg(0, 1);
    rd(`CPM_OFF_SAVE); `CHK(v, n[2])
    `CHK(done_out, 1'b1)
    arm(`CPM_MODE_BUF_PERIOD, 1'b0, 1'b0);
    push(33'h100000000);
    align;
    for (i = 0; i < 6; i++) begin
      seg(1, 1);
      seg(0, n[i] - 1);
      push(n[i]);
    end
    seg(1, 2);
    rd(`CPM_OFF_SAVE); `CHK(v, n[5])
    rd(`CPM_OFF_STATUS); `CHK(v[3:2], {ovr, 1'b1})
    drain(5);
    `CHK(acc / 3, (n[0] + n[1] + n[2]) / 3)
    seg(0, 1);
    arm(`CPM_MODE_BUF_SEMI, 1'b0, 1'b0);
    push(33'h100000000);
    align;
    seg(1, n[3]);
    push(n[3]);
    seg(0, n[4]);
    push(n[4]);
    seg(1, n[5]);
    push(n[5]);
    seg(0, 2);
    drain(5);
    tally_and_finish;
  end
endmodule

/* File: cpm_counter.v */
/*
  Period and semi-period measurement counter with a save register and a
  buffered path toward host memory through a small FIFO.
  Assumes window and count inputs come from pins (asynchronous) and that the
  count input is slower than a quarter of clk_in. Registers over a plain port.
*/
`timescale 1ns/1ps
`include "cpm_regs.vh"

module cpm_counter #(
  parameter CW = 32,
  parameter FIFO_DEPTH = `CPM_FIFO_DEPTH,
  parameter FIFO_AW = 2
) (
  input wire clk_in,
  input wire rst_in,
  input wire window_in,
  input wire count_in,
  input wire [`CPM_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  output reg done_out,
  output reg data_valid_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_MEAS = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [2:0] win_sync_reg;
  reg [2:0] cnt_sync_reg;
  reg win_level_reg;
  reg cnt_level_reg;
  reg [31:0] ctrl_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CW-1:0] count_reg;
  reg [CW-1:0] count_next;
  reg [CW-1:0] save_reg;
  reg [CW-1:0] save_next;
  reg latch_now;
  reg overrun_reg;
  reg overrun_next;
  reg [31:0] ctrl_next;
  reg [31:0] status_word;
  reg [31:0] rdata_next;
  wire win_agree;
  wire cnt_agree;
  wire win_rise;
  wire win_fall;
  wire cnt_rise;
  wire cnt_fall;
  wire win_edge_any;
  wire win_active_edge;
  wire win_inactive_edge;
  wire cnt_edge;
  wire armed;
  wire win_fall_sel;
  wire [1:0] mode;
  wire buffered;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [CW-1:0] fifo_out_data;
  wire fifo_pop;
  wire arm_write;
  wire arm_rise;
  wire [31:0] save_word;
  wire [31:0] count_word;
  wire [31:0] head_word;

  // Window pin: a change counts once the second and third stages agree
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_sync_reg <= 3'h0;
      win_level_reg <= 1'b0;
    end else begin
      win_sync_reg <= {win_sync_reg[1:0], window_in};
      if (win_agree) begin
        win_level_reg <= win_sync_reg[2];
      end
    end
  end

  // Count pin: same filter, so both pins see the same latency
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_sync_reg <= 3'h0;
      cnt_level_reg <= 1'b0;
    end else begin
      cnt_sync_reg <= {cnt_sync_reg[1:0], count_in};
      if (cnt_agree) begin
        cnt_level_reg <= cnt_sync_reg[2];
      end
    end
  end

  assign win_agree = (win_sync_reg[1] == win_sync_reg[2]);
  assign cnt_agree = (cnt_sync_reg[1] == cnt_sync_reg[2]);
  assign win_rise = win_agree & win_sync_reg[2] & ~win_level_reg;
  assign win_fall = win_agree & ~win_sync_reg[2] & win_level_reg;
  assign cnt_rise = cnt_agree & cnt_sync_reg[2] & ~cnt_level_reg;
  assign cnt_fall = cnt_agree & ~cnt_sync_reg[2] & cnt_level_reg;

  assign armed = ctrl_reg[`CPM_CTRL_ARM];
  assign win_fall_sel = ctrl_reg[`CPM_CTRL_WIN_FALL];
  assign mode = ctrl_reg[`CPM_CTRL_MODE_HI:`CPM_CTRL_MODE_LO];
  assign buffered = (mode == `CPM_MODE_BUF_PERIOD) | (mode == `CPM_MODE_BUF_SEMI);
  assign win_edge_any = win_rise | win_fall;
  // In single modes the active edge opens the window; for pulse width the opposite edge closes it
  assign win_active_edge = win_fall_sel ? win_fall : win_rise;
  assign win_inactive_edge = win_fall_sel ? win_rise : win_fall;
  assign cnt_edge = ctrl_reg[`CPM_CTRL_CNT_FALL] ? cnt_fall : cnt_rise;
  assign arm_write = wr_in & (addr_in == `CPM_OFF_CTRL);
  assign arm_rise = arm_write & wdata_in[`CPM_CTRL_ARM] & ~armed;

  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    latch_now = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Pins are ignored until armed
        if (armed) begin
          state_next = buffered ? ST_MEAS : ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Single modes wait for the opening edge; arming mid-pulse is skipped
        if (win_active_edge) begin
          state_next = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (cnt_edge) begin
          count_next = count_reg + {{(CW-1){1'b0}}, 1'b1};
        end
        case (mode)
          `CPM_MODE_PERIOD: begin
            if (win_active_edge) begin
              latch_now = 1'b1;
              state_next = ST_DONE;
            end
          end
          `CPM_MODE_BUF_PERIOD: begin
            latch_now = win_active_edge;
          end
          `CPM_MODE_SEMI: begin
            // Same sequence as single period, but closed by the inactive edge
            if (win_inactive_edge) begin
              latch_now = 1'b1;
              state_next = ST_DONE;
            end
          end
          default: begin
            latch_now = win_edge_any;
          end
        endcase
        if (latch_now) begin
          count_next = {CW{1'b0}};
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!armed) begin
      state_next = ST_IDLE;
    end
    // Rearming restarts the count even if the old run stopped mid-interval
    if (arm_rise) begin
      count_next = {CW{1'b0}};
    end
  end

  // Arm rise wins over a latch: both can come in the cycle after a disarm, while the state is still ST_MEAS
  always @* begin
    ctrl_next = ctrl_reg;
    save_next = save_reg;
    overrun_next = overrun_reg;
    if (arm_write) begin
      ctrl_next = {27'h0, wdata_in[4:0]};
    end
    if (arm_rise) begin
      save_next = {CW{1'b0}};
      overrun_next = 1'b0;
    end else if (latch_now) begin
      save_next = count_reg;
      // Full FIFO drops the value; software sees the overrun flag
      if (buffered & ~fifo_in_ready) begin
        overrun_next = 1'b1;
      end
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= `CPM_CTRL_RESET;
      state_reg <= ST_IDLE;
      count_reg <= {CW{1'b0}};
      save_reg <= {CW{1'b0}};
      overrun_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      state_reg <= state_next;
      count_reg <= count_next;
      save_reg <= save_next;
      overrun_reg <= overrun_next;
    end
  end

  // Buffered values wait here until software pops them through the data register
  assign fifo_pop = rd_in & (addr_in == `CPM_OFF_DATA);

  cpm_fifo #(
    .WIDTH(CW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(arm_rise),
    .in_valid_in(latch_now & buffered),
    .in_ready_out(fifo_in_ready),
    .in_data_in(count_reg),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // Status bits sit at the positions fixed in the register header
  always @* begin
    status_word = 32'h00000000;
    status_word[`CPM_ST_ARMED] = armed;
    status_word[`CPM_ST_DONE] = (state_reg == ST_DONE);
    status_word[`CPM_ST_FIFO_VALID] = fifo_out_valid;
    status_word[`CPM_ST_OVERRUN] = overrun_reg;
  end

  // Bus words are 32 bits: a narrower count is zero-extended, a wider one cut
  generate
    if (CW < 32) begin : g_narrow
      assign save_word = {{(32-CW){1'b0}}, save_reg};
      assign count_word = {{(32-CW){1'b0}}, count_reg};
      assign head_word = {{(32-CW){1'b0}}, fifo_out_data};
    end else begin : g_wide
      assign save_word = save_reg[31:0];
      assign count_word = count_reg[31:0];
      assign head_word = fifo_out_data[31:0];
    end
  endgenerate

  // Read data stand for one cycle only and are zero otherwise
  always @* begin
    rdata_next = 32'h00000000;
    if (rd_in) begin
      case (addr_in)
        `CPM_OFF_CTRL: rdata_next = ctrl_reg;
        `CPM_OFF_STATUS: rdata_next = status_word;
        `CPM_OFF_SAVE: rdata_next = save_word;
        `CPM_OFF_DATA: rdata_next = fifo_out_valid ? head_word : 32'h00000000;
        `CPM_OFF_COUNT: rdata_next = count_word;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Done follows the next state so it rises with the latch, not a cycle later
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
      done_out <= 1'b0;
      data_valid_out <= 1'b0;
    end else begin
      rdata_out <= rdata_next;
      done_out <= (state_next == ST_DONE);
      data_valid_out <= fifo_out_valid;
    end
  end
endmodule

/* File: cpm_counter_sva.sv */
/* Port checker of cpm_counter: register bus answers, done and FIFO flags.
   Assumes it is bound to every cpm_counter instance. */
`timescale 1ns/1ps
module cpm_counter_sva (
  input wire clk_in,
  input wire rst_in,
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire done_out,
  input wire data_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  rd_idle_a: assert property (!rd_in |=> rdata_out == 32'h0) else $error("read data outside read slot");
  unmapped_zero_a: assert property (rd_in && addr_in > 4'h4 |=> rdata_out == 32'h0) else $error("unmapped read");
  ctrl_back_a: assert property (wr_in && addr_in == 4'h0 ##1 rd_in && !wr_in && addr_in == 4'h0
    |=> rdata_out[4:0] == $past(wdata_in[4:0], 2)) else $error("control readback wrong");
  done_hold_a: assert property ($fell(done_out) |-> $past(wr_in) || $past(wr_in, 2)) else $error("done dropped");
  done_stat_a: assert property (rd_in && addr_in == 4'h1 && done_out && !$past(wr_in) && !wr_in
    |=> rdata_out[1]) else $error("status misses done");
  stat_valid_a: assert property (rd_in && addr_in == 4'h1 && data_valid_out && !$past(rd_in) && !$past(wr_in)
    |=> rdata_out[2]) else $error("status misses fifo data");
  valid_hold_a: assert property ($fell(data_valid_out)
    |-> $past(rd_in) || $past(wr_in) || $past(rd_in, 2) || $past(wr_in, 2)) else $error("fifo data vanished");
  disarm_clear_a: assert property (wr_in && addr_in == 4'h0 && !wdata_in[0] |-> ##[1:3] !done_out) else $error("done kept");
endmodule
bind cpm_counter cpm_counter_sva chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .done_out(done_out), .data_valid_out(data_valid_out));

/* File: cpm_fifo.v */
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module cpm_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_in,
  input wire rst_in,
  input wire flush_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] fill_reg;
  wire push;
  wire pop;

  assign in_ready_out = (fill_reg != DEPTH[AW:0]);
  assign out_valid_out = (fill_reg != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      fill_reg <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      fill_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        fill_reg <= fill_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        fill_reg <= fill_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* File: cpm_regs.vh */
/*
  Register map, field positions, reset values and mode codes of the period counter.
  Assumes inclusion by bare name from the design files in the same folder.
*/
`ifndef CPM_REGS_VH
`define CPM_REGS_VH

`define CPM_ADDR_W 4
`define CPM_OFF_CTRL 4'h0
`define CPM_OFF_STATUS 4'h1
`define CPM_OFF_SAVE 4'h2
`define CPM_OFF_DATA 4'h3
`define CPM_OFF_COUNT 4'h4

`define CPM_CTRL_ARM 0
`define CPM_CTRL_WIN_FALL 1
`define CPM_CTRL_CNT_FALL 2
`define CPM_CTRL_MODE_LO 3
`define CPM_CTRL_MODE_HI 4
`define CPM_CTRL_RESET 32'h00000000

`define CPM_MODE_PERIOD 2'h0
`define CPM_MODE_BUF_PERIOD 2'h1
`define CPM_MODE_SEMI 2'h2
`define CPM_MODE_BUF_SEMI 2'h3

`define CPM_ST_ARMED 0
`define CPM_ST_DONE 1
`define CPM_ST_FIFO_VALID 2
`define CPM_ST_OVERRUN 3

`define CPM_FIFO_DEPTH 4

`endif

/* File: cpm_source.sv */
/* Count source model: free-running square wave of known period on the count pin.
   Assumes the bench places window changes two cycles after its rising edges. */
`timescale 1ns/1ps
module cpm_source #(
  parameter HALF = 4
) (
  input wire clk_in,
  output reg count_out
);
  integer ph = 0;
  initial count_out = 1'b0;
  // Known fast timebase on the count pin; the signal under test drives the window
  // Highs and lows of HALF cycles, one pulse in every 2*HALF clk_in cycles
  always @(posedge clk_in) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      count_out <= ~count_out;
    end
  end
endmodule
